// *** rtl/mshp_pkg.sv ***
// Shared constants and types for the serial register-access port.
// Assumes a 10 MHz core clock on both ends.
package mshp_pkg;

  // ==========================================================
  // Frame layout
  localparam int ADDR_W       = 7;
  localparam int DATA_W       = 16;
  localparam int FRAME_BITS   = 24;
  localparam int ADDR_END_BIT = 8;
  localparam int CNT_W        = 5;
  localparam logic [CNT_W-1:0] CNT_SAT = 5'h19;

  // ==========================================================
  // Register map
  localparam logic [ADDR_W-1:0] SOFT_RESET_KEY_ADDR      = 7'h00;
  localparam logic [ADDR_W-1:0] LAST_TRANSFER_VALUE_ADDR = 7'h06;
  localparam logic [DATA_W-1:0] SOFT_RESET_KEY           = 16'h789A;
  localparam logic [DATA_W-1:0] LAST_TRANSFER_VALUE_RST  = 16'h0000;

  // ==========================================================
  // Timing
  localparam int CLK_FREQ_MHZ     = 10;
  localparam int IDLE_LOW_US      = 400;
  localparam int IDLE_LOW_CYC     = IDLE_LOW_US * CLK_FREQ_MHZ;
  localparam int TIMEOUT_MS       = 6;
  localparam int TIMEOUT_CYC_DEF  = TIMEOUT_MS * 1000 * CLK_FREQ_MHZ;
  localparam int HW_RESET_US      = 200;
  localparam int HW_RESET_CYC_DEF = HW_RESET_US * CLK_FREQ_MHZ + 1;
  localparam int SETUP_CYC        = 16;
  localparam int SCLK_HALF_CYC    = 4;
  localparam int GAP_CYC          = 8;

  // ==========================================================
  // Pin synchroniser slots
  localparam int PIN_CS   = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_RSTN = 2;
  localparam int PIN_SEL  = 3;
  localparam logic [3:0] PIN_RST_LVL = 4'h7;

  // ==========================================================
  // State machines
  typedef enum logic [2:0] {
    DEV_IDLE    = 3'h1,
    DEV_ACTIVE  = 3'h2,
    DEV_WAIT_HI = 3'h4
  } mshp_dev_state_t;

  typedef enum logic [5:0] {
    HST_IDLE = 6'h01,
    HST_LEAD = 6'h02,
    HST_LOW  = 6'h04,
    HST_HIGH = 6'h08,
    HST_TAIL = 6'h10,
    HST_RST  = 6'h20
  } mshp_host_state_t;

endpackage : mshp_pkg

// *** rtl/mshp_link_if.sv ***
// Serial link between host controller and metering port.
// Assumes a pull-up on the data-out wire when nobody drives it.
`timescale 1ns/1ps
interface mshp_link_if;
  logic csN;
  logic sclk;
  logic sdi;
  logic sdoOut;
  logic sdoOe;
  logic sdoLine;
  logic resetN;
  logic portSelect;

  // ==========================================================
  // Wire resolution: released line floats high
  assign sdoLine = sdoOe ? sdoOut : 1'b1;

  modport device (
    input  csN,
    input  sclk,
    input  sdi,
    input  resetN,
    input  portSelect,
    output sdoOut,
    output sdoOe
  );

  modport host (
    output csN,
    output sclk,
    output sdi,
    output resetN,
    output portSelect,
    input  sdoLine
  );
endinterface : mshp_link_if

// *** rtl/mshp_device_end.sv ***
// Metering device side of the serial register port.
// Assumes the host leaves setup time after chip select or the idle-low start
// before the first rising serial clock edge.
`timescale 1ns/1ps

// Function
// - Select input low enables serial port
// - Sample rising edge, launch falling edge
// - Completed read, or write to address zero, captured in last-transfer register
// - Host keeps chip select low whole frame
// - Read: one, address, sixteen data out
// - Write: zero, address, sixteen data in
// - Three-wire start after 400 us low
// - Abort frame after 6 ms idle clock
// - Over-length frame: no write, read valid
// - Unmapped read returns all zeros
// - Unmapped write is discarded
// - Four-wire completion depends on cycle count
// - Three-wire read timeout before 24 partial
// - Three-wire counts carry until next start or timeout
// - Any reset restores register defaults
// - Host holds reset pin over 200 us
// - Key to address zero causes reset
// - Only exact key triggers reset
module mshp_device_end import mshp_pkg::*; #(
  parameter int TIMEOUT_CYC = TIMEOUT_CYC_DEF
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              threeWire,
  mshp_link_if.device            link,
  output logic [DATA_W-1:0]      lastTransferValue,
  output logic                   softResetPulse,
  output logic                   uartSelected
);

  localparam int TO_W = $clog2(TIMEOUT_CYC + 1);
  localparam int LC_W = $clog2(IDLE_LOW_CYC + 1);

  // ==========================================================
  // Declarations
  logic [3:0]            syncA_r;
  logic [3:0]            syncB_r;
  logic [3:0]            syncC_r;
  logic [3:0]            pinLvl_r;
  logic [3:0]            pinLvl_nxt;
  logic                  hwReset;
  logic                  coreReset;
  logic                  sclkPrev_r;
  logic                  sclkToggle;
  logic [LC_W-1:0]       lowCnt_r;
  logic [TO_W-1:0]       idleCnt_r;
  logic                  timeout;
  logic                  startSeen;
  logic                  restart;
  logic                  frameEnd;
  logic                  wrOk;
  logic                  rdOk;
  logic                  linkClr_r;
  mshp_dev_state_t       state_r;
  mshp_dev_state_t       state_nxt;
  logic [CNT_W-1:0]      bitCnt_r;
  logic [FRAME_BITS-1:0] rxShift_r;
  logic                  rwBit_r;
  logic [DATA_W-1:0]     txWord_r;
  logic [DATA_W-1:0]     readMux;
  logic [ADDR_W-1:0]     liveAddr;
  logic [3:0]            txIdx;
  logic                  sdoBit_r;
  logic                  sdoDrive_r;
  logic [ADDR_W-1:0]     frameAddr;
  logic [DATA_W-1:0]     frameData;

  // ==========================================================
  // Pin synchronisers: a change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (reset) begin
      syncA_r <= PIN_RST_LVL;
      syncB_r <= PIN_RST_LVL;
      syncC_r <= PIN_RST_LVL;
    end else begin
      syncA_r <= {link.portSelect, link.resetN, link.sclk, link.csN};
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
    end
  end

  assign pinLvl_nxt = (~(syncB_r ^ syncC_r) & syncC_r) | ((syncB_r ^ syncC_r) & pinLvl_r);

  always_ff @(posedge clk) begin
    if (reset) begin
      pinLvl_r <= PIN_RST_LVL;
    end else begin
      pinLvl_r <= pinLvl_nxt;
    end
  end

  // ==========================================================
  // Reset sources
  assign hwReset   = ~pinLvl_r[PIN_RSTN];
  assign coreReset = reset | hwReset | softResetPulse;

  // Strap is caught while reset stands, so a later change is ignored
  always_ff @(posedge clk) begin
    if (reset | hwReset) begin
      uartSelected <= pinLvl_r[PIN_SEL];
    end
  end

  // ==========================================================
  // Clock activity, idle-low start and timeout
  always_ff @(posedge clk) begin
    if (coreReset) begin
      sclkPrev_r <= 1'b1;
    end else begin
      sclkPrev_r <= pinLvl_r[PIN_SCLK];
    end
  end

  assign sclkToggle = sclkPrev_r != pinLvl_r[PIN_SCLK];

  always_ff @(posedge clk) begin
    if (coreReset || pinLvl_r[PIN_SCLK]) begin
      lowCnt_r <= '0;
    end else if (lowCnt_r != LC_W'(IDLE_LOW_CYC)) begin
      lowCnt_r <= lowCnt_r + 1'b1;
    end
  end

  // Level form lets a start follow directly after a timed-out frame
  assign startSeen = threeWire ? (lowCnt_r >= LC_W'(IDLE_LOW_CYC - 1)) && !pinLvl_r[PIN_SCLK]
                               : !pinLvl_r[PIN_CS];
  assign restart   = threeWire && (lowCnt_r == LC_W'(IDLE_LOW_CYC - 1)) && !pinLvl_r[PIN_SCLK];

  always_ff @(posedge clk) begin
    if (coreReset || state_r != DEV_ACTIVE || sclkToggle) begin
      idleCnt_r <= '0;
    end else if (!timeout) begin
      idleCnt_r <= idleCnt_r + 1'b1;
    end
  end

  assign timeout = idleCnt_r == TO_W'(TIMEOUT_CYC - 1);

  // ==========================================================
  // Frame control
  // Three-wire frames end only at the next start or at timeout, so stray cycles accumulate
  assign frameEnd = (state_r == DEV_ACTIVE) &&
                    (timeout || (threeWire ? restart : pinLvl_r[PIN_CS]));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DEV_IDLE: begin
        if (!uartSelected && startSeen) begin
          state_nxt = DEV_ACTIVE;
        end
      end
      DEV_ACTIVE: begin
        if (frameEnd) begin
          state_nxt = (timeout && !threeWire) ? DEV_WAIT_HI : DEV_IDLE;
        end
      end
      DEV_WAIT_HI: begin
        if (pinLvl_r[PIN_CS]) begin
          state_nxt = DEV_IDLE;
        end
      end
      default: state_nxt = DEV_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (coreReset) begin
      state_r   <= DEV_IDLE;
      linkClr_r <= 1'b1;
    end else begin
      state_r   <= state_nxt;
      linkClr_r <= state_nxt != DEV_ACTIVE;
    end
  end

  // ==========================================================
  // Commit: link words are still while the frame-end event is seen
  assign frameAddr = rxShift_r[FRAME_BITS-2 -: ADDR_W];
  assign frameData = rxShift_r[DATA_W-1:0];

  assign wrOk = !rwBit_r && bitCnt_r == CNT_W'(FRAME_BITS) && !timeout
                && frameAddr == SOFT_RESET_KEY_ADDR;
  assign rdOk = rwBit_r && bitCnt_r >= CNT_W'(FRAME_BITS);

  always_ff @(posedge clk) begin
    if (coreReset) begin
      lastTransferValue <= LAST_TRANSFER_VALUE_RST;
    end else if (frameEnd && rdOk) begin
      lastTransferValue <= txWord_r;
    end else if (frameEnd && wrOk) begin
      lastTransferValue <= frameData;
    end
  end

  always_ff @(posedge clk) begin
    if (reset | hwReset) begin
      softResetPulse <= 1'b0;
    end else begin
      softResetPulse <= frameEnd && wrOk && frameData == SOFT_RESET_KEY;
    end
  end

  // ==========================================================
  // Link domain: cleared by the frame controller between frames
  assign liveAddr = {rxShift_r[ADDR_W-2:0], link.sdi};
  assign readMux  = (liveAddr == LAST_TRANSFER_VALUE_ADDR) ? lastTransferValue
                                                           : '0;

  always_ff @(posedge link.sclk or posedge linkClr_r) begin
    if (linkClr_r) begin
      bitCnt_r <= '0;
    end else if (bitCnt_r != CNT_SAT) begin
      bitCnt_r <= bitCnt_r + 1'b1;
    end
  end

  always_ff @(posedge link.sclk or posedge linkClr_r) begin
    if (linkClr_r) begin
      rxShift_r <= '0;
      rwBit_r   <= 1'b0;
    end else if (bitCnt_r < CNT_W'(FRAME_BITS)) begin
      rxShift_r <= {rxShift_r[FRAME_BITS-2:0], link.sdi};
      if (bitCnt_r == '0) begin
        rwBit_r <= link.sdi;
      end
    end
  end

  always_ff @(posedge link.sclk or posedge linkClr_r) begin
    if (linkClr_r) begin
      txWord_r <= '0;
    end else if (bitCnt_r == CNT_W'(ADDR_END_BIT - 1)) begin
      txWord_r <= readMux;
    end
  end

  // ==========================================================
  // Output launch on falling edges
  assign txIdx = 4'(FRAME_BITS - 1 - int'(bitCnt_r));

  always_ff @(negedge link.sclk or posedge linkClr_r) begin
    if (linkClr_r) begin
      sdoBit_r   <= 1'b1;
      sdoDrive_r <= 1'b0;
    end else begin
      sdoDrive_r <= rwBit_r && bitCnt_r >= CNT_W'(ADDR_END_BIT)
                    && bitCnt_r < CNT_W'(FRAME_BITS);
      sdoBit_r   <= txWord_r[txIdx];
    end
  end

  // In four-wire mode chip select release stops driving at once, ahead of the slow clear; three-wire mode ignores chip select
  assign link.sdoOut = sdoBit_r;
  assign link.sdoOe  = sdoDrive_r && (threeWire || !link.csN);

endmodule : mshp_device_end

// *** rtl/mshp_host_end.sv ***
// Host controller side of the serial register port.
// Assumes the device samples the link pins with its own core clock.
`timescale 1ns/1ps
module mshp_host_end import mshp_pkg::*; #(
  parameter int HW_RESET_CYC = HW_RESET_CYC_DEF,
  parameter int HALF_CYC     = SCLK_HALF_CYC
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              threeWire,
  input  wire logic              portSelect,
  input  wire logic              hwResetReq,
  input  wire logic              reqValid,
  output logic                   reqReady,
  input  wire logic              reqRead,
  input  wire logic [ADDR_W-1:0] reqAddr,
  input  wire logic [DATA_W-1:0] reqData,
  output logic                   doneValid,
  output logic [DATA_W-1:0]      doneData,
  mshp_link_if.host              link
);

  localparam int HC_W = $clog2(HW_RESET_CYC + IDLE_LOW_CYC + SETUP_CYC + GAP_CYC + 1);

  // ==========================================================
  // Declarations
  mshp_host_state_t      state_r;
  logic [HC_W-1:0]       cnt_r;
  logic [CNT_W-1:0]      bitIdx_r;
  logic [FRAME_BITS-1:0] txFrame_r;
  logic [2:0]            sdoSync_r;
  logic                  sdoLvl_r;
  logic                  phaseDone;
  logic [HC_W-1:0]       leadLen;

  // ==========================================================
  // Data-out synchroniser
  always_ff @(posedge clk) begin
    if (reset) begin
      sdoSync_r <= 3'h7;
      sdoLvl_r  <= 1'b1;
    end else begin
      sdoSync_r <= {sdoSync_r[1:0], link.sdoLine};
      if (sdoSync_r[1] == sdoSync_r[2]) begin
        sdoLvl_r <= sdoSync_r[2];
      end
    end
  end

  assign leadLen   = threeWire ? HC_W'(IDLE_LOW_CYC + SETUP_CYC) : HC_W'(SETUP_CYC);
  assign phaseDone = cnt_r == HC_W'(HALF_CYC - 1);
  assign reqReady  = state_r == HST_IDLE;

  // ==========================================================
  // Frame sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r         <= HST_IDLE;
      cnt_r           <= '0;
      bitIdx_r        <= '0;
      txFrame_r       <= '0;
      link.csN        <= 1'b1;
      link.sclk       <= 1'b1;
      link.sdi        <= 1'b1;
      link.resetN     <= 1'b1;
      link.portSelect <= 1'b0;
      doneValid       <= 1'b0;
      doneData        <= '0;
    end else begin
      doneValid <= 1'b0;
      cnt_r     <= cnt_r + 1'b1;
      case (state_r)
        HST_IDLE: begin
          cnt_r <= '0;
          link.portSelect <= portSelect;
          // Three-wire mode keeps chip select low at all times after reset; reset drives it high
          link.csN        <= !threeWire;
          if (hwResetReq) begin
            link.resetN <= 1'b0;
            state_r     <= HST_RST;
          end else if (reqValid) begin
            txFrame_r <= {reqRead, reqAddr, reqData};
            bitIdx_r  <= '0;
            if (threeWire) begin
              link.sclk <= 1'b0;
            end else begin
              link.csN <= 1'b0;
            end
            state_r <= HST_LEAD;
          end
        end
        HST_LEAD: begin
          if (cnt_r == leadLen - 1'b1) begin
            cnt_r     <= '0;
            link.sclk <= 1'b0;
            link.sdi  <= txFrame_r[FRAME_BITS-1];
            state_r   <= HST_LOW;
          end
        end
        HST_LOW: begin
          if (phaseDone) begin
            cnt_r     <= '0;
            link.sclk <= 1'b1;
            state_r   <= HST_HIGH;
          end
        end
        HST_HIGH: begin
          if (phaseDone) begin
            cnt_r    <= '0;
            bitIdx_r <= bitIdx_r + 1'b1;
            if (bitIdx_r >= CNT_W'(ADDR_END_BIT)) begin
              doneData <= {doneData[DATA_W-2:0], sdoLvl_r};
            end
            if (bitIdx_r == CNT_W'(FRAME_BITS - 1)) begin
              state_r <= HST_TAIL;
            end else begin
              txFrame_r <= {txFrame_r[FRAME_BITS-2:0], 1'b0};
              link.sdi  <= txFrame_r[FRAME_BITS-2];
              link.sclk <= 1'b0;
              state_r   <= HST_LOW;
            end
          end
        end
        HST_TAIL: begin
          // Chip select stays low for GAP_CYC cycles after the last high phase is over
          if (cnt_r == HC_W'(GAP_CYC - 1)) begin
            link.csN  <= !threeWire;
            link.sdi  <= 1'b1;
            doneValid <= 1'b1;
            state_r   <= HST_IDLE;
          end
        end
        HST_RST: begin
          if (cnt_r == HC_W'(HW_RESET_CYC - 1)) begin
            link.resetN <= 1'b1;
            state_r     <= HST_IDLE;
          end
        end
        default: state_r <= HST_IDLE;
      endcase
    end
  end

endmodule : mshp_host_end

// *** tb/mshp_link_properties.sv ***
// Checker on the joined host/device link.
// Assumes one core clock for both ends and a synchronous high reset.
`timescale 1ns/1ps
module mshp_link_properties #(
  parameter int HW_RESET_CYC = 10
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic csN,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdoOut,
  input wire logic sdoOe,
  input wire logic sdoLine,
  input wire logic resetN,
  input wire logic portSelect
);
  logic [15:0] lowCnt_r;
  logic [15:0] rstLow_r;
  logic [4:0]  riseCnt_r;
  logic        rw_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ========
  // Frame tracking
  // Long low sclk is a three-wire start, so it clears the count too
  always_ff @(posedge clk) begin
    if (reset || sclk) lowCnt_r <= 16'h0000;
    else if (lowCnt_r != 16'hFFFF) lowCnt_r <= lowCnt_r + 16'h0001;
  end
  always_ff @(posedge clk) begin
    if (reset || csN || lowCnt_r == 16'h0FA0) riseCnt_r <= 5'h00;
    else if ($rose(sclk) && riseCnt_r != 5'h1F) riseCnt_r <= riseCnt_r + 5'h01;
  end
  always_ff @(posedge clk) begin
    if (reset) rw_r <= 1'b0;
    else if ($rose(sclk) && riseCnt_r == 5'h00) rw_r <= sdi;
  end
  always_ff @(posedge clk) begin
    if (reset || resetN) rstLow_r <= 16'h0000;
    else rstLow_r <= rstLow_r + 16'h0001;
  end

  // ========
  // Properties
  chk_frame_len: assert property ($rose(csN) |-> riseCnt_r == 5'h18)
    else $error("frame not 24 clocks");
  chk_cs_idle: assert property (csN |-> sclk)
    else $error("sclk low outside frame");
  chk_sdi_setup: assert property ($rose(sclk) |-> $stable(sdi))
    else $error("sdi moved at rising sclk");
  chk_sdo_released: assert property (csN |-> !sdoOe)
    else $error("sdo driven while deselected");
  chk_read_drive: assert property ($fell(sclk) && rw_r && riseCnt_r == 5'h08
    |-> ##[1:6] sdoOe)
    else $error("read data not driven");
  chk_cs_lead: assert property ($fell(csN) |-> sclk [*8])
    else $error("no setup after select");
  chk_reset_width: assert property ($rose(resetN) |-> rstLow_r >= HW_RESET_CYC)
    else $error("reset pulse too short");
  chk_port_static: assert property ($stable(portSelect))
    else $error("port select changed");

  cover property ($rose(csN) && rw_r);
  cover property ($rose(csN) && !rw_r);
  cover property (lowCnt_r == 16'h0FA0);
  cover property (sdoOe && !sdoLine);
endmodule : mshp_link_properties

// *** tb/metering_spi_host_port_bench.sv ***
// Bench: host and device joined on one link, a second device on a raw link.
// Assumes the design package and interface are compiled first.
`timescale 1ns/1ps
module metering_spi_host_port_bench;
  import mshp_pkg::*;
  localparam int HW_CYC = 10;
  logic              clk;
  logic              reset;
  logic              threeWire;
  logic              hwResetReq;
  logic              reqValid;
  logic              reqRead;
  logic              reqReady;
  logic              doneValid;
  logic              softPulse;
  logic [ADDR_W-1:0] reqAddr;
  logic [ADDR_W-1:0] a;
  logic [DATA_W-1:0] reqData;
  logic [DATA_W-1:0] doneData;
  logic [DATA_W-1:0] lastVal;
  logic [DATA_W-1:0] lastVal2;
  logic [DATA_W-1:0] v;
  logic [31:0]       lfsr;
  int                failures = 0;
  int                nChecks = 0;
  int                cycles = 0;
  int                pulses = 0;
  int                mLast = 0;
  int                p;

  mshp_link_if link ();
  mshp_link_if link2 ();
  mshp_host_end #(.HW_RESET_CYC(HW_CYC)) mshp_host_end_inst (.clk(clk), .reset(reset),
    .threeWire(threeWire), .portSelect(1'b0), .hwResetReq(hwResetReq), .reqValid(reqValid),
    .reqReady(reqReady), .reqRead(reqRead), .reqAddr(reqAddr), .reqData(reqData),
    .doneValid(doneValid), .doneData(doneData), .link(link));
  mshp_device_end #(.TIMEOUT_CYC(200)) mshp_device_end_inst (.clk(clk), .reset(reset),
    .threeWire(threeWire), .link(link), .lastTransferValue(lastVal),
    .softResetPulse(softPulse), .uartSelected());
  mshp_device_end #(.TIMEOUT_CYC(200)) mshp_device_end_inst2 (.clk(clk), .reset(reset),
    .threeWire(1'b0), .link(link2), .lastTransferValue(lastVal2), .softResetPulse(),
    .uartSelected());
  mshp_link_properties #(.HW_RESET_CYC(HW_CYC)) mshp_link_properties_inst (.clk(clk),
    .reset(reset), .csN(link.csN), .sclk(link.sclk), .sdi(link.sdi), .sdoOut(link.sdoOut),
    .sdoOe(link.sdoOe), .sdoLine(link.sdoLine), .resetN(link.resetN),
    .portSelect(link.portSelect));

  // ========
  // Clock, watchdog and helpers
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (softPulse === 1'b1) pulses <= pulses + 1;
    if (cycles == 30000) begin
      failures++;
      $display("[ERR] %0t run hung", $time);
      test_done();
    end
  end

  function automatic logic [31:0] nextRand(input logic [31:0] s);
    nextRand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nextRand

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d failures %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  // One host request; the model predicts read data and the stored value
  task automatic xfer(input logic rd, input logic [6:0] ad, input logic [15:0] d);
    int n;
    n = 0;
    reqRead = rd;
    reqAddr = ad;
    reqData = d;
    reqValid = 1'b1;
    while (reqReady !== 1'b1) @(negedge clk);
    @(negedge clk);
    reqValid = 1'b0;
    while (doneValid !== 1'b1 && n < 9000) begin
      @(negedge clk);
      n++;
    end
    if (n == 9000) begin
      failures++;
      $display("[ERR] %0t no done from host", $time);
      test_done();
    end
    if (rd) begin
      check(doneData, ad == 7'h06 ? mLast[15:0] : 16'h0000);
      if (ad != 7'h06) mLast = 0;
    end else if (ad == 7'h00 && !threeWire) begin
      // A three-wire write can only end by timeout, which suppresses it
      mLast = d == 16'h789A ? 0 : int'(d);
    end
    // Three-wire commits only at timeout, hence the longer wait
    repeat (threeWire ? 300 : 12) @(negedge clk);
    check(lastVal, mLast[15:0]);
  endtask : xfer

  // Bit-banged four-wire frame; the high phase after rise stall outlasts timeout
  task automatic raw(input int n, input logic [23:0] b, input int stall);
    link2.csN = 1'b0;
    repeat (8) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      link2.sclk = 1'b0;
      link2.sdi = i < 24 ? b[23-i] : ~link2.sdi;
      repeat (4) @(negedge clk);
      link2.sclk = 1'b1;
      repeat (i == stall ? 300 : 4) @(negedge clk);
    end
    link2.csN = 1'b1;
    repeat (12) @(negedge clk);
  endtask : raw

  // ========
  // Main sequence
  initial begin
    reset = 1'b1;
    threeWire = 1'b0;
    hwResetReq = 1'b0;
    reqValid = 1'b0;
    reqRead = 1'b0;
    reqAddr = 7'h00;
    reqData = 16'h0000;
    lfsr = 32'hF801147B;
    link2.csN = 1'b1;
    link2.sclk = 1'b1;
    link2.sdi = 1'b1;
    link2.resetN = 1'b1;
    link2.portSelect = 1'b0;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    repeat (8) @(negedge clk);
    check(lastVal, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      lfsr = nextRand(lfsr);
      xfer(1'b0, 7'h00, lfsr[15:0] | 16'h8000);
      xfer(1'b1, 7'h06, 16'h0000);
    end
    // Bit 15 set keeps random data clear of the reset key
    v = lfsr[31:16] | 16'h8000;
    a = lfsr[6:0] | 7'h40;
    xfer(1'b0, 7'h06, v);
    xfer(1'b0, a, v);
    xfer(1'b1, a, 16'h0000);
    xfer(1'b0, 7'h00, v);
    p = pulses;
    xfer(1'b0, 7'h00, 16'h789A);
    check(16'(pulses - p), 16'h0001);
    xfer(1'b0, 7'h00, 16'h789B);
    check(16'(pulses - p), 16'h0001);
    hwResetReq = 1'b1;
    repeat (2) @(negedge clk);
    hwResetReq = 1'b0;
    repeat (40) @(negedge clk);
    mLast = 0;
    check(lastVal, 16'h0000);
    $display("four-wire host test done");
    raw(24, {8'h00, v}, 99);
    check(lastVal2, v);
    raw(25, {8'h00, v ^ 16'h00FF}, 99);
    check(lastVal2, v);
    raw(23, {8'h00, v ^ 16'h00FF}, 99);
    check(lastVal2, v);
    raw(24, {8'h00, v ^ 16'h00FF}, 10);
    check(lastVal2, v);
    raw(10, {8'h80, 16'h0000}, 99);
    check(lastVal2, v);
    raw(30, {8'h80, 16'h0000}, 99);
    check(lastVal2, 16'h0000);
    $display("raw frame test done");
    reset = 1'b1;
    threeWire = 1'b1;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    repeat (8) @(negedge clk);
    mLast = 0;
    xfer(1'b0, 7'h00, v);
    xfer(1'b1, 7'h06, 16'h0000);
    $display("three-wire test done");
    test_done();
  end
endmodule : metering_spi_host_port_bench
